/* File: hdl/pit_pkg.sv */
// Shared constants and types for the three-counter interval timer.
// Assumes a byte-wide I/O port bus and a 20 MHz system clock.
package pit_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Port addresses.
   localparam logic [7:0] COUNTER0_COUNT_PORT = 8'h40;
   localparam logic [7:0] COUNTER1_COUNT_PORT = 8'h41;
   localparam logic [7:0] COUNTER2_COUNT_PORT = 8'h42;
   localparam logic [7:0] TIMER_CONTROL_WORD  = 8'h43;
   localparam logic [7:0] SPEAKER_CTRL_PORT   = 8'h61;

   ////////////////////////////////////////////////////////////////////////////
   // Control word fields.
   localparam int SEL_MSB     = 7;
   localparam int SEL_LSB     = 6;
   localparam int RW_MSB      = 5;
   localparam int RW_LSB      = 4;
   localparam int MODE_MSB    = 3;
   localparam int MODE_LSB    = 1;
   localparam int BCD_BIT     = 0;
   localparam int RB_NO_COUNT = 5;
   localparam int RB_NO_STAT  = 4;

   localparam logic [1:0] SEL_READBACK = 2'h3;
   localparam logic [1:0] RW_LATCH     = 2'h0;
   localparam logic [1:0] RW_LSB_ONLY  = 2'h1;
   localparam logic [1:0] RW_MSB_ONLY  = 2'h2;
   localparam logic [1:0] RW_BOTH      = 2'h3;

   // Speaker control port fields.
   localparam int SPK_GATE_BIT = 0;
   localparam int SPK_EN_BIT   = 1;
   localparam int SPK_OUT_BIT  = 5;
   localparam logic [1:0] SPK_CTRL_RESET = 2'h0;

   // Counter configuration after reset: mode 0, binary, both bytes.
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [1:0] RW_RESET   = RW_BOTH;

   ////////////////////////////////////////////////////////////////////////////
   // Count clock made from the system clock by a phase accumulator.
   localparam int SYS_CLK_KHZ = 20000;
   localparam int CNT_CLK_KHZ = 1193;
   localparam logic [14:0] ACC_MOD  = 15'(SYS_CLK_KHZ);
   localparam logic [14:0] ACC_STEP = 15'(CNT_CLK_KHZ);

   // Programmed behaviour of one counter.
   typedef struct packed {
      logic [1:0] rw;
      logic [2:0] mode;
      logic       bcd;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{rw: RW_RESET, mode: MODE_RESET, bcd: 1'b0};

endpackage : pit_pkg

/* File: hdl/pit_counter_core.sv */
// One down-counter of the interval timer with its six operating modes.
// Assumes tick is a one-cycle strobe at the count clock rate.
`timescale 1ns/100ps
`default_nettype none
module pit_counter_core (
   input  wire logic           clk,
   input  wire logic           rst_b,
   input  wire logic           tick,
   input  wire logic           gate,
   input  wire logic           arm,
   input  wire pit_pkg::ctrl_t cfg,
   input  wire logic           load_req,
   input  wire logic [15:0]    load_val,
   output logic [15:0]         count,
   output logic                out_lvl,
   output logic                null_cnt
);

   ////////////////////////////////////////////////////////////////////////////
   // Decrement by one in binary or four-digit BCD; zero wraps to the top.
   function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
      logic [15:0] r;
      logic        brw;
      r   = v;
      brw = 1'b1;
      if (!bcd) begin
         r = v - 16'h0001;
      end else begin
         for (int d = 0; d < 4; d++) begin
            if (brw) begin
               if (v[d*4 +: 4] == 4'h0) begin
                  r[d*4 +: 4] = 4'h9;
               end else begin
                  r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                  brw         = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : dec1

   logic [2:0]  mode;
   logic        hw_trig;
   logic        gate_q;
   logic        trig;
   logic        pending;
   logic        running;
   logic [15:0] hold;

   // Modes 6 and 7 alias modes 2 and 3.
   assign mode    = (cfg.mode[2:1] == 2'h3) ? {1'b0, cfg.mode[1:0]} : cfg.mode;
   assign hw_trig = (mode == 3'h1) || (mode == 3'h5);

   // Square-wave load: an odd count spends one more tick high than low.
   function automatic logic [15:0] sq_load(input logic [15:0] n, input logic hi);
      sq_load = n;
      if (n[0]) begin
         sq_load = hi ? n : dec1(n, 1'b0);
      end
   endfunction : sq_load

   ////////////////////////////////////////////////////////////////////////////
   // Gate rising edge is caught at clock rate and held until the next tick.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gate_q <= 1'b1;  // Idle high, so a tied-high gate shows no false edge.
         trig   <= 1'b0;
      end else begin
         gate_q <= gate;
         if (gate && !gate_q) begin
            trig <= 1'b1;
         end else if (tick || arm) begin
            trig <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counting element. A control word stops the counter; a written count loads
   // on the next tick with the gate high, but at the next reload once modes 2
   // and 3 are running, or on a gate trigger in modes 1 and 5.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count    <= 16'h0000;
         hold     <= 16'h0000;
         out_lvl  <= 1'b0;
         null_cnt <= 1'b1;
         pending  <= 1'b0;
         running  <= 1'b0;
      end else if (arm) begin
         out_lvl  <= (mode != 3'h0);
         null_cnt <= 1'b1;
         pending  <= 1'b0;
         running  <= 1'b0;
      end else if (load_req) begin
         hold     <= load_val;
         pending  <= 1'b1;
         null_cnt <= 1'b1;
         if (mode == 3'h0) begin
            out_lvl <= 1'b0;
         end
      end else if (tick) begin
         if (hw_trig && trig && (pending || running)) begin
            count    <= hold;
            running  <= 1'b1;
            pending  <= 1'b0;
            null_cnt <= 1'b0;
            out_lvl  <= (mode == 3'h5);
         end else if (!hw_trig && pending && gate &&
                      (!running || mode == 3'h0 || mode == 3'h4)) begin
            count    <= (mode == 3'h3) ? sq_load(hold, 1'b1) : hold;
            running  <= 1'b1;
            pending  <= 1'b0;
            null_cnt <= 1'b0;
            out_lvl  <= (mode != 3'h0);
         end else if (running && (mode == 3'h2 || mode == 3'h3) && !gate) begin
            out_lvl <= 1'b1;
         end else if (running && (mode == 3'h2 || mode == 3'h3) && trig) begin
            count    <= (mode == 3'h3) ? sq_load(hold, 1'b1) : hold;
            out_lvl  <= 1'b1;
            pending  <= 1'b0;
            null_cnt <= 1'b0;
         end else if (running && (gate || hw_trig)) begin
            case (mode)
               3'h0, 3'h1: begin
                  count <= dec1(count, cfg.bcd);
                  if (count == 16'h0001) begin
                     out_lvl <= 1'b1;
                  end
               end
               3'h2: begin
                  if (count == 16'h0001) begin
                     count    <= hold;
                     out_lvl  <= 1'b1;
                     pending  <= 1'b0;
                     null_cnt <= 1'b0;
                  end else begin
                     count   <= dec1(count, cfg.bcd);
                     out_lvl <= (count != 16'h0002);
                  end
               end
               3'h3: begin
                  if (count == 16'h0002 || count == 16'h0001) begin
                     count    <= sq_load(hold, !out_lvl);
                     out_lvl  <= !out_lvl;
                     pending  <= 1'b0;
                     null_cnt <= 1'b0;
                  end else begin
                     count <= dec1(dec1(count, cfg.bcd), cfg.bcd);
                  end
               end
               default: begin
                  count   <= dec1(count, cfg.bcd);
                  out_lvl <= (count != 16'h0001);
               end
            endcase
         end else if (hw_trig && !running) begin
            out_lvl <= 1'b1;
         end
      end
   end

endmodule : pit_counter_core
`default_nettype wire

/* File: hdl/interval_timer_speaker_tone.sv */
// Three-counter interval timer with speaker gating on byte-wide I/O ports.
// Assumes io_rd and io_wr are one-cycle strobes synchronous to clk.
//
// Functional notes
// - Counter 0 free-runs and drives tick interrupt.
// - Counter 2 gated by speaker port bit 0.
// - Speaker equals counter 2 output AND bit 1.
// - Speaker port bit 5 reads counter 2 output.
// - Control word selects counter, mode, BCD format.
// - Latch command snapshots count; counting continues.
// - Read-back returns count, mode, output, null flag.
// - Port 40h reads and writes counter 0.
// - Port 41h reads and writes counter 1.
// - Port 42h reads and writes counter 2.
// - Port 43h takes control, latch, read-back words.
`timescale 1ns/100ps
`default_nettype none
module interval_timer_speaker_tone #(
   parameter int NUM_CNT = 3
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [7:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   output logic            system_tick_interrupt,
   output logic            speaker_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Count clock strobe.
   logic [14:0] acc;
   logic        tick;
   logic [15:0] acc_sum;

   assign acc_sum = {1'b0, acc} + {1'b0, pit_pkg::ACC_STEP};

   // A phase accumulator gives the mean count rate exactly; single ticks
   // jitter by one system clock, which the counters cannot see.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         acc  <= 15'h0000;
         tick <= 1'b0;
      end else if (acc_sum >= {1'b0, pit_pkg::ACC_MOD}) begin
         acc  <= 15'(acc_sum - {1'b0, pit_pkg::ACC_MOD});
         tick <= 1'b1;
      end else begin
         acc  <= acc_sum[14:0];
         tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port decode.
   logic       wr_ctrl;
   logic       wr_spk;
   logic       rd_spk;
   logic [1:0] cw_sel;
   logic [1:0] cw_rw;
   logic       rb_cmd;

   assign wr_ctrl = io_wr && (io_addr == pit_pkg::TIMER_CONTROL_WORD);
   assign wr_spk  = io_wr && (io_addr == pit_pkg::SPEAKER_CTRL_PORT);
   assign rd_spk  = io_rd && (io_addr == pit_pkg::SPEAKER_CTRL_PORT);
   assign cw_sel  = io_wdata[pit_pkg::SEL_MSB:pit_pkg::SEL_LSB];
   assign cw_rw   = io_wdata[pit_pkg::RW_MSB:pit_pkg::RW_LSB];
   assign rb_cmd  = wr_ctrl && (cw_sel == pit_pkg::SEL_READBACK);

   ////////////////////////////////////////////////////////////////////////////
   // Speaker control bits: gate for counter 2 and speaker enable.
   logic [1:0] spk_ctrl;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         spk_ctrl <= pit_pkg::SPK_CTRL_RESET;
      end else if (wr_spk) begin
         spk_ctrl <= {io_wdata[pit_pkg::SPK_EN_BIT], io_wdata[pit_pkg::SPK_GATE_BIT]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-counter access logic and counting element.
   logic [NUM_CNT-1:0] gate_vec;
   logic [NUM_CNT-1:0] out_vec;
   logic [7:0]         rd_byte [NUM_CNT];
   logic [NUM_CNT-1:0] rd_hit;

   // Counter 0 gate is held high; counter 1 has no gate source and is left
   // enabled so software that programs it still sees it count.
   assign gate_vec[0] = 1'b1;
   assign gate_vec[1] = 1'b1;
   assign gate_vec[2] = spk_ctrl[0];

   for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      localparam logic [7:0] PORT = pit_pkg::COUNTER0_COUNT_PORT + 8'(i);

      pit_pkg::ctrl_t cfg;
      pit_pkg::ctrl_t cfg_in;
      logic           wr_cnt;
      logic           rd_cnt;
      logic           cw_hit;
      logic           latch_cmd;
      logic           rb_count;
      logic           rb_stat;
      logic           wr_msb_next;
      logic           rd_msb_next;
      logic [7:0]     lsb_buf;
      logic           load_req;
      logic [15:0]    load_val;
      logic [15:0]    live;
      logic           null_cnt;
      logic [15:0]    ol;
      logic           ol_valid;
      logic           ol_msb_next;
      logic [7:0]     stat;
      logic           stat_valid;
      logic [15:0]    src;
      logic           src_msb;

      assign wr_cnt    = io_wr && (io_addr == PORT);
      assign rd_cnt    = io_rd && (io_addr == PORT);
      assign rd_hit[i] = rd_cnt;
      assign cw_hit    = wr_ctrl && (cw_sel == 2'(i));
      assign latch_cmd = cw_hit && (cw_rw == pit_pkg::RW_LATCH);
      assign rb_count  = rb_cmd && io_wdata[i+1] && !io_wdata[pit_pkg::RB_NO_COUNT];
      assign rb_stat   = rb_cmd && io_wdata[i+1] && !io_wdata[pit_pkg::RB_NO_STAT];

      // Control word: counter select, access order, mode and BCD.
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            cfg <= pit_pkg::CTRL_RESET;
         end else if (cw_hit && !latch_cmd) begin
            cfg.rw   <= cw_rw;
            cfg.mode <= io_wdata[pit_pkg::MODE_MSB:pit_pkg::MODE_LSB];
            cfg.bcd  <= io_wdata[pit_pkg::BCD_BIT];
         end
      end

      // The core sees the incoming word in the cycle it is written, so the
      // arm step sets the output level of the new mode rather than the old.
      assign cfg_in = (cw_hit && !latch_cmd) ?
                      pit_pkg::ctrl_t'{cw_rw, io_wdata[pit_pkg::MODE_MSB:pit_pkg::MODE_LSB],
                                       io_wdata[pit_pkg::BCD_BIT]} : cfg;

      // Count writes: one or two bytes per the access order, LSB first.
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            wr_msb_next <= 1'b0;
            lsb_buf     <= 8'h00;
         end else if (cw_hit && !latch_cmd) begin
            wr_msb_next <= 1'b0;
         end else if (wr_cnt && cfg.rw == pit_pkg::RW_BOTH) begin
            wr_msb_next <= !wr_msb_next;
            if (!wr_msb_next) begin
               lsb_buf <= io_wdata;
            end
         end
      end

      always_comb begin
         load_req = 1'b0;
         load_val = 16'h0000;
         if (wr_cnt) begin
            case (cfg.rw)
               pit_pkg::RW_LSB_ONLY: begin
                  load_req = 1'b1;
                  load_val = {8'h00, io_wdata};
               end
               pit_pkg::RW_MSB_ONLY: begin
                  load_req = 1'b1;
                  load_val = {io_wdata, 8'h00};
               end
               pit_pkg::RW_BOTH: begin
                  load_req = wr_msb_next;
                  load_val = {io_wdata, lsb_buf};
               end
               default: begin
                  load_req = 1'b0;
                  load_val = 16'h0000;
               end
            endcase
         end
      end

      pit_counter_core u_core (
         .clk      (clk),
         .rst_b    (rst_b),
         .tick     (tick),
         .gate     (gate_vec[i]),
         .arm      (cw_hit && !latch_cmd),
         .cfg      (cfg_in),
         .load_req (load_req),
         .load_val (load_val),
         .count    (live),
         .out_lvl  (out_vec[i]),
         .null_cnt (null_cnt)
      );

      // Count latch: first command wins until the latched value is read out.
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            ol       <= 16'h0000;
            ol_valid <= 1'b0;
         end else if ((latch_cmd || rb_count) && !ol_valid) begin
            ol       <= live;
            ol_valid <= 1'b1;
         end else if (rd_cnt && !stat_valid && ol_valid &&
                      (cfg.rw != pit_pkg::RW_BOTH || ol_msb_next)) begin
            ol_valid <= 1'b0;
         end
      end

      // Status latch for read-back; it is read ahead of any latched count.
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            stat       <= 8'h00;
            stat_valid <= 1'b0;
         end else if (rb_stat && !stat_valid) begin
            stat       <= {out_vec[i], null_cnt, cfg.rw, cfg.mode, cfg.bcd};
            stat_valid <= 1'b1;
         end else if (rd_cnt) begin
            stat_valid <= 1'b0;
         end
      end

      // Read byte order toggles in two-byte access; a control word restarts it.
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            rd_msb_next <= 1'b0;
         end else if (cw_hit && !latch_cmd) begin
            rd_msb_next <= 1'b0;
         end else if (rd_cnt && !stat_valid && cfg.rw == pit_pkg::RW_BOTH) begin
            rd_msb_next <= !rd_msb_next;
         end
      end

      assign ol_msb_next = rd_msb_next;
      assign src         = ol_valid ? ol : live;
      assign src_msb     = (cfg.rw == pit_pkg::RW_MSB_ONLY) ||
                           (cfg.rw == pit_pkg::RW_BOTH && rd_msb_next);

      always_comb begin
         if (stat_valid) begin
            rd_byte[i] = stat;
         end else if (src_msb) begin
            rd_byte[i] = src[15:8];
         end else begin
            rd_byte[i] = src[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data: registered one cycle after the read strobe. The control
   // word port is write-only and unmapped addresses read as zero.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         io_rdata <= 8'h00;
         for (int k = 0; k < NUM_CNT; k++) begin
            if (rd_hit[k]) begin
               io_rdata <= rd_byte[k];
            end
         end
         if (rd_spk) begin
            io_rdata <= {2'h0, out_vec[2], 3'h0, spk_ctrl};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs. Software is expected to leave the enable set when idle so the
   // speaker rests high and draws less power; hardware does not enforce it.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         system_tick_interrupt <= 1'b0;
         speaker_out           <= 1'b0;
      end else begin
         system_tick_interrupt <= out_vec[0];
         speaker_out           <= out_vec[2] & spk_ctrl[1];
      end
   end

endmodule : interval_timer_speaker_tone
`default_nettype wire

/* File: tb/interval_timer_speaker_tone_assertions.sv */
// Concurrent checks on the interval timer's I/O port and output pins.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module interval_timer_speaker_tone_assertions #(
   parameter int NUM_CNT = 3
) (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [7:0] io_addr,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic       system_tick_interrupt,
   input wire logic       speaker_out
);
   default clocking dflt @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic [1:0] spk_ctrl;
   logic       c0_touched;
   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the speaker control bits, kept from the host's writes.
   always_ff @(posedge clk) begin
      if (!rst_b) spk_ctrl <= 2'h0;
      else if (io_wr && io_addr == 8'h61) spk_ctrl <= io_wdata[1:0];
   end
   // Counter 0 cannot move its output before software first programs it.
   always_ff @(posedge clk) begin
      if (!rst_b) c0_touched <= 1'b0;
      else if (io_wr && (io_addr == 8'h40 || (io_addr == 8'h43 && io_wdata[7:6] == 2'h0)))
         c0_touched <= 1'b1;
   end
   sequence spk_off2;
      !spk_ctrl[1] ##1 !spk_ctrl[1];
   endsequence
   sequence c0_mode0_ctrl;
      io_wr && io_addr == 8'h43 && io_wdata[7:6] == 2'h0 && io_wdata[5:1] inside {5'h08, 5'h10, 5'h18};
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
      else $error("read data moved without a read");
   ctrl_read_zero_a: assert property (io_rd && io_addr == 8'h43 |=> io_rdata == 8'h00)
      else $error("control port read not zero");
   unmapped_read_a: assert property (io_rd && !(io_addr inside {[8'h40:8'h43], 8'h61})
      |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   spk_port_read_a: assert property (io_rd && io_addr == 8'h61 |=> io_rdata[1:0] == $past(spk_ctrl)
      && io_rdata[4:2] == 3'h0 && io_rdata[7:6] == 2'h0)
      else $error("speaker port read bits wrong");
   spk_idle_low_a: assert property (spk_off2 |-> !speaker_out)
      else $error("speaker high while disabled");
   tick_idle_a: assert property (!c0_touched |-> !system_tick_interrupt)
      else $error("tick output moved before programming");
   tick_low_min_a: assert property ($fell(system_tick_interrupt) |=> !system_tick_interrupt[*8])
      else $error("tick output low too briefly");
   mode0_ctrl_low_a: assert property (c0_mode0_ctrl |-> ##[1:3] !system_tick_interrupt)
      else $error("mode 0 control write left output high");
endmodule : interval_timer_speaker_tone_assertions
bind interval_timer_speaker_tone interval_timer_speaker_tone_assertions #(.NUM_CNT(NUM_CNT))
   interval_timer_speaker_tone_assertions_i (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
   .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
   .system_tick_interrupt(system_tick_interrupt), .speaker_out(speaker_out));
`default_nettype wire

/* File: tb/pit_host_model.sv */
// Host processor model issuing byte I/O reads and writes.
// Assumes strobes are driven at the falling clock edge, one cycle each.
`timescale 1ns/100ps
`default_nettype none
module pit_host_model (
   input  wire logic       clk,
   output logic      [7:0] io_addr,
   output logic            io_wr,
   output logic            io_rd,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata
);
   // Idle bus at time zero.
   initial begin
      io_addr = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // Released lines show the inverse so stale values are never read as valid.
   task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      io_addr = addr;
      io_wdata = data;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
      io_wdata = ~data;
      io_addr = ~addr;
   endtask : io_write
   // Read data is taken one cycle after the strobe's edge.
   task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk);
      io_addr = addr;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      io_addr = ~addr;
      @(negedge clk);
      data = io_rdata;
   endtask : io_read
endmodule : pit_host_model
`default_nettype wire

/* File: tb/interval_timer_speaker_tone_tb_top.sv */
// Self-checking bench for the interval timer with speaker gating.
// Assumes the host model drives the I/O port and the design runs at 20 MHz.
`timescale 1ns/100ps
`default_nettype none
module interval_timer_speaker_tone_tb_top;
   logic        clk;
   logic        rst_b;
   logic [7:0]  io_addr;
   logic        io_wr;
   logic        io_rd;
   logic [7:0]  io_wdata;
   logic [7:0]  io_rdata;
   logic        system_tick_interrupt;
   logic        speaker_out;
   logic [7:0]  d;
   logic [7:0]  hi;
   logic [15:0] v1;
   int          failures;
   int          total_checks;
   int          irq_falls;
   int          spk_rises;
   int          ones;
   logic        irq_q;
   logic        spk_q;
   interval_timer_speaker_tone interval_timer_speaker_tone_i (.clk(clk), .rst_b(rst_b),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .system_tick_interrupt(system_tick_interrupt),
      .speaker_out(speaker_out));
   pit_host_model pit_host_model_i (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
   ////////////////////////////////////////////////////////////////////////////
   // Free-running 50 ns clock.
   initial clk = 1'b0;
   always #25 clk = ~clk;
   // Edge counters for the two outputs, sampled where they are settled.
   always @(negedge clk) begin
      if (irq_q === 1'b1 && system_tick_interrupt === 1'b0) irq_falls++;
      if (spk_q === 1'b0 && speaker_out === 1'b1) spk_rises++;
      irq_q = system_tick_interrupt;
      spk_q = speaker_out;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   // Cut a hang short: the tests need about 2800 cycles.
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      rst_b = 1'b0;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      pit_host_model_i.io_read(8'h61, d); check(d, 8'h00);
      pit_host_model_i.io_read(8'h43, d); check(d, 8'h00);
      pit_host_model_i.io_read(8'h50, d); check(d, 8'h00);
      // Counter 1, mode 0: a frozen snapshot against a later one.
      pit_host_model_i.io_write(8'h43, 8'h70);
      pit_host_model_i.io_write(8'h41, 8'h34);
      pit_host_model_i.io_write(8'h41, 8'h12);
      repeat (40) @(negedge clk);
      pit_host_model_i.io_write(8'h43, 8'h40);
      repeat (170) @(negedge clk);
      pit_host_model_i.io_read(8'h41, d);
      pit_host_model_i.io_read(8'h41, hi);
      v1 = {hi, d};
      check({7'h0, v1 <= 16'h1234 && v1 >= 16'h1220}, 8'h01);
      pit_host_model_i.io_write(8'h43, 8'h40);
      pit_host_model_i.io_read(8'h41, d);
      pit_host_model_i.io_read(8'h41, hi);
      v1 = v1 - {hi, d};
      check({7'h0, v1 >= 16'd9 && v1 <= 16'd12}, 8'h01);
      // Counter 2, mode 3 square wave of 16 ticks on the speaker.
      pit_host_model_i.io_write(8'h61, 8'h03);
      pit_host_model_i.io_write(8'h43, 8'hb6);
      pit_host_model_i.io_write(8'h42, 8'h10);
      pit_host_model_i.io_write(8'h42, 8'h00);
      spk_rises = 0;
      repeat (1100) @(negedge clk);
      check({7'h0, spk_rises >= 3 && spk_rises <= 5}, 8'h01);
      pit_host_model_i.io_write(8'h61, 8'h01);
      @(negedge clk);
      spk_rises = 0;
      ones = 0;
      for (int i = 0; i < 20; i++) begin
         pit_host_model_i.io_read(8'h61, d);
         ones += int'(d[5]);
         repeat (10) @(negedge clk);
      end
      check({7'h0, ones >= 5 && ones <= 15}, 8'h01);
      check(8'(spk_rises), 8'h00);
      // With the gate low a square wave holds high, and bit 5 still shows it.
      pit_host_model_i.io_write(8'h61, 8'h00);
      repeat (20) @(negedge clk);
      pit_host_model_i.io_read(8'h61, d); check(d, 8'h20);
      // Idle speaker is left driven high, as software is meant to do.
      pit_host_model_i.io_write(8'h61, 8'h02);
      repeat (5) @(negedge clk);
      check({7'h0, speaker_out}, 8'h01);
      // Counter 0, mode 2 rate of 5 ticks on the tick interrupt.
      pit_host_model_i.io_write(8'h43, 8'h34);
      pit_host_model_i.io_write(8'h40, 8'h05);
      pit_host_model_i.io_write(8'h40, 8'h00);
      irq_falls = 0;
      repeat (1000) @(negedge clk);
      check({7'h0, irq_falls >= 11 && irq_falls <= 12}, 8'h01);
      pit_host_model_i.io_write(8'h43, 8'hc2);
      pit_host_model_i.io_read(8'h40, d); check(d & 8'h7f, 8'h34);
      pit_host_model_i.io_read(8'h40, d);
      pit_host_model_i.io_read(8'h40, hi); check(hi, 8'h00);
      check({7'h0, d >= 8'h01 && d <= 8'h05}, 8'h01);
      // Counter 0 back to mode 0: its output must drop at the control word.
      pit_host_model_i.io_write(8'h43, 8'h30);
      repeat (3) @(negedge clk);
      check({7'h0, system_tick_interrupt}, 8'h00);
      // Counter 1 in BCD: status, then a count whose digits stay decimal.
      pit_host_model_i.io_write(8'h43, 8'h71);
      pit_host_model_i.io_write(8'h41, 8'h00);
      pit_host_model_i.io_write(8'h41, 8'h10);
      repeat (100) @(negedge clk);
      pit_host_model_i.io_write(8'h43, 8'he4);
      pit_host_model_i.io_read(8'h41, d); check(d & 8'h7f, 8'h31);
      pit_host_model_i.io_write(8'h43, 8'h40);
      pit_host_model_i.io_read(8'h41, d);
      pit_host_model_i.io_read(8'h41, hi); check(hi, 8'h09);
      check({7'h0, d[7:4] == 4'h9 && d[3:0] <= 4'h9}, 8'h01);
      give_verdict();
   end
endmodule : interval_timer_speaker_tone_tb_top
`default_nettype wire
